// *** card_cmd_checker.sv ***
// Card-side checker for authentication, toolkit and get-response commands.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Authentication P1 must be zero; algorithm comes from the selected application.
// - Authentication P2 top bit: clear means global key, set means specific key.
// - Authentication P2 low five bits give key number one to thirty-one.
// - Authentication P2 all zero means key implied by selected application.
// - Authentication carries Lc data and Le; card returns Le bytes.
// - Terminal profile: P1 and P2 zero, Lc data, no Le, no data back.
// - Envelope: P1 and P2 zero, Lc data, Le gives expected length.
// - Fetch: P1 and P2 zero, no Lc, Le gives expected length.
// - Terminal response: P1 and P2 zero, Lc data, no Le.
// - Card holds response data after authentication, search, select, increase.
// - Out-of-order get-response is answered with technical problem status.
// - Get-response is accepted as first command after activation.
module card_cmd_checker
    import card_cmd_pkg::*;
#(
    parameter int DEPTH = RESP_DEPTH
) (
    input  wire logic     clk_sys,
    input  wire logic     rst,
    input  wire logic     cmd_valid,
    output logic          cmd_ready,
    input  wire cmd_hdr_t cmd_hdr,
    output logic          verdict_valid,
    output verdict_t      verdict,
    input  wire logic     resp_load_valid,
    output logic          resp_load_ready,
    input  wire logic [7:0] resp_load_data,
    output logic          out_valid,
    output logic [7:0]    out_data,
    output logic          out_last
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 1 || DEPTH > 256) $error("card_cmd_checker: DEPTH must be 1 to 256");
    end

    typedef enum {S_IDLE, S_STREAM} state_t;

    state_t          state;
    logic            related;
    logic            first_cmd;
    logic [LW-1:0]   resp_len;
    logic [LW-1:0]   rd_count;
    logic [LW-1:0]   rd_left;
    logic [AW-1:0]   rd_addr;
    logic            rd_issue;
    logic            rd_issue_last;
    logic [7:0]      rd_data;
    logic            cmd_taken;
    status_t         next_status;
    logic [LW-1:0]   next_count;

    assign cmd_ready       = (state == S_IDLE);
    assign resp_load_ready = (state == S_IDLE) && !cmd_valid;
    assign cmd_taken       = cmd_valid && cmd_ready;

    function automatic logic params_zero(input cmd_hdr_t c);
        return (c.p1 == PARAM_FIXED) && (c.p2 == PARAM_FIXED);
    endfunction

    function automatic status_t check_cmd(input cmd_hdr_t c, input logic rel,
                                          input logic [LW-1:0] len);
        logic [4:0] knum;
        knum = c.p2[KEY_NUM_HI:0];
        unique case (c.kind)
            CMD_AUTH: begin
                if (c.p1 != PARAM_FIXED) return ST_WRONG_PARAM;
                if (c.p2[RFU_HI_BIT:RFU_LO_BIT] != RFU_VALUE) return ST_WRONG_PARAM;
                if (c.p2 != PARAM_FIXED && (knum < KEY_NUM_MIN || knum > KEY_NUM_MAX))
                    return ST_WRONG_PARAM;
                if (!c.lc_present || !c.le_present) return ST_WRONG_LEN;
                return ST_OK;
            end
            CMD_PROFILE, CMD_TERM_RESP: begin
                if (!params_zero(c)) return ST_WRONG_PARAM;
                if (!c.lc_present || c.le_present) return ST_WRONG_LEN;
                return ST_OK;
            end
            CMD_ENVELOPE: begin
                if (!params_zero(c)) return ST_WRONG_PARAM;
                if (!c.lc_present || !c.le_present) return ST_WRONG_LEN;
                return ST_OK;
            end
            CMD_FETCH: begin
                if (!params_zero(c)) return ST_WRONG_PARAM;
                if (c.lc_present || !c.le_present) return ST_WRONG_LEN;
                return ST_OK;
            end
            CMD_GET_RESP: begin
                if (!rel) return ST_TECH_PROBLEM;
                if (!params_zero(c)) return ST_WRONG_PARAM;
                if (c.lc_present || !c.le_present) return ST_WRONG_LEN;
                if (c.le != LE_ALL && LW'(c.le) != len) return ST_WRONG_LEN;
                return ST_OK;
            end
            default: return ST_OK;
        endcase
    endfunction

    always_comb begin
        next_status = check_cmd(cmd_hdr, related, resp_len);
        next_count  = (cmd_hdr.le == LE_ALL) ? resp_len : LW'(cmd_hdr.le);
    end

    // Verdict register: one cycle after the command is taken.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            verdict_valid <= 1'b0;
            verdict       <= '0;
        end else begin
            verdict_valid <= cmd_taken;
            if (cmd_taken) begin
                verdict.status       <= next_status;
                verdict.key_specific <= (cmd_hdr.kind == CMD_AUTH) &&
                                        cmd_hdr.p2[KEY_SCOPE_BIT];
                verdict.key_implicit <= (cmd_hdr.kind == CMD_AUTH) &&
                                        (cmd_hdr.p2 == PARAM_FIXED);
                verdict.key_number   <= (cmd_hdr.kind == CMD_AUTH) ?
                                        cmd_hdr.p2[KEY_NUM_HI:0] : 5'h00;
                verdict.data_len     <= (cmd_hdr.kind == CMD_GET_RESP && next_status == ST_OK) ?
                                        9'(next_count) : 9'h000;
            end
        end
    end

    // Any command breaks the chain; only an accepted related command re-arms it.
    // Reset arms it because the root_directory is implicitly selected.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            related <= 1'b1;
        end else if (cmd_taken) begin
            related <= (next_status == ST_OK) &&
                       (cmd_hdr.kind inside {CMD_AUTH, CMD_SEARCH, CMD_SELECT,
                                             CMD_INCREASE});
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_cmd <= 1'b1;
        end else if (cmd_taken) begin
            first_cmd <= 1'b0;
        end
    end

    // Response length: cleared when any command other than get-response arrives, grown by the loader.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            resp_len <= '0;
        end else if (cmd_taken && cmd_hdr.kind != CMD_GET_RESP) begin
            resp_len <= '0;
        end else if (resp_load_valid && resp_load_ready && resp_len < LW'(DEPTH)) begin
            resp_len <= resp_len + LW'(1);
        end
    end

    resp_store #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_store (
        .clk_sys (clk_sys),
        .wr_en   (resp_load_valid && resp_load_ready && resp_len < LW'(DEPTH)),
        .wr_addr (resp_len[AW-1:0]),
        .wr_data (resp_load_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // Streaming of held data after an accepted get-response.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state   <= S_IDLE;
            rd_left <= '0;
            rd_addr <= '0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    rd_addr <= '0;
                    if (cmd_taken && cmd_hdr.kind == CMD_GET_RESP &&
                        next_status == ST_OK && next_count != '0) begin
                        state   <= S_STREAM;
                        rd_left <= next_count;
                    end
                end
                S_STREAM: begin
                    rd_addr <= rd_addr + AW'(1);
                    rd_left <= rd_left - LW'(1);
                    if (rd_left == LW'(1)) begin
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_issue      <= 1'b0;
            rd_issue_last <= 1'b0;
        end else begin
            rd_issue      <= (state == S_STREAM);
            rd_issue_last <= (state == S_STREAM) && (rd_left == LW'(1));
        end
    end

    assign out_valid = rd_issue;
    assign out_data  = rd_data;
    assign out_last  = rd_issue_last;

    // Helper: bytes streamed so far in the current answer.
    always_ff @(posedge clk_sys) begin
        if (rst || cmd_taken) begin
            rd_count <= '0;
        end else if (out_valid) begin
            rd_count <= rd_count + LW'(1);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_gr_ok;
        cmd_taken && cmd_hdr.kind == CMD_GET_RESP && next_status == ST_OK &&
        next_count != '0;
    endsequence

    sequence s_stream_done;
        out_valid && out_last;
    endsequence

    verdict_timing_a: assert property (cmd_taken |=> verdict_valid)
        else $error("verdict missing one cycle after command");

    auth_p1_a: assert property (cmd_taken && cmd_hdr.kind == CMD_AUTH &&
                                cmd_hdr.p1 != 8'h00 |=> verdict.status == ST_WRONG_PARAM)
        else $error("authentication with nonzero P1 not rejected");

    key_scope_a: assert property (cmd_taken && cmd_hdr.kind == CMD_AUTH
                                  |=> verdict.key_specific == $past(cmd_hdr.p2[7]))
        else $error("key scope does not follow P2 top bit");

    rfu_bits_a: assert property (cmd_taken && cmd_hdr.kind == CMD_AUTH &&
                                 cmd_hdr.p1 == 8'h00 && cmd_hdr.p2[6:5] != 2'h0
                                 |=> verdict.status == ST_WRONG_PARAM)
        else $error("reserved P2 bits accepted");

    key_range_a: assert property (verdict_valid && verdict.status == ST_OK &&
                                  $past(cmd_hdr.kind) == CMD_AUTH && !verdict.key_implicit
                                  |-> verdict.key_number != 5'h00)
        else $error("accepted key number out of range");

    key_implicit_a: assert property (cmd_taken && cmd_hdr.kind == CMD_AUTH &&
                                     cmd_hdr.p2 == 8'h00 |=> verdict.key_implicit)
        else $error("zero P2 not flagged as implicit key");

    no_le_a: assert property (cmd_taken && cmd_hdr.kind inside {CMD_PROFILE, CMD_TERM_RESP} &&
                              cmd_hdr.p1 == 8'h00 && cmd_hdr.p2 == 8'h00 && cmd_hdr.le_present
                              |=> verdict.status == ST_WRONG_LEN)
        else $error("Le accepted on a command that has none");

    fetch_lc_a: assert property (cmd_taken && cmd_hdr.kind == CMD_FETCH &&
                                 cmd_hdr.p1 == 8'h00 && cmd_hdr.p2 == 8'h00 && cmd_hdr.lc_present
                                 |=> verdict.status == ST_WRONG_LEN)
        else $error("fetch with Lc accepted");

    gr_order_a: assert property (cmd_taken && cmd_hdr.kind == CMD_GET_RESP && !related
                                 |=> verdict.status == ST_TECH_PROBLEM)
        else $error("out-of-order get-response not refused");

    gr_first_a: assert property (cmd_taken && first_cmd && cmd_hdr.kind == CMD_GET_RESP
                                 |=> verdict.status != ST_TECH_PROBLEM)
        else $error("first get-response after activation refused");

    stream_len_a: assert property (s_gr_ok ##1 (!out_valid) ##[1:257] s_stream_done
                                   |-> rd_count == LW'(verdict.data_len) - LW'(1))
        else $error("streamed byte count differs from granted length");

    stream_start_a: assert property (s_gr_ok |=> !cmd_ready ##1 out_valid)
        else $error("held data does not start two cycles after get-response");

    stream_run_a: assert property (out_valid && !out_last |=> out_valid)
        else $error("held data stream has a gap");

    env_len_a: assert property (cmd_taken && cmd_hdr.kind == CMD_ENVELOPE &&
                                cmd_hdr.p1 == 8'h00 && cmd_hdr.p2 == 8'h00 &&
                                !cmd_hdr.lc_present |=> verdict.status == ST_WRONG_LEN)
        else $error("envelope without Lc accepted");

    tr_param_a: assert property (cmd_taken && cmd_hdr.kind == CMD_TERM_RESP &&
                                 cmd_hdr.p2 != 8'h00 |=> verdict.status == ST_WRONG_PARAM)
        else $error("terminal response with nonzero P2 accepted");

    chain_drop_a: assert property (cmd_taken &&
                                   !(cmd_hdr.kind inside {CMD_AUTH, CMD_SEARCH, CMD_SELECT,
                                                         CMD_INCREASE}) |=> !related)
        else $error("get-response chain survives an unrelated command");

endmodule // card_cmd_checker
`default_nettype wire

// *** card_cmd_pkg.sv ***
// Shared types and constants for the card-side command checker.
`default_nettype none
package card_cmd_pkg;

    // Command kinds as decoded upstream from the class and instruction bytes.
    typedef enum logic [3:0] {
        CMD_AUTH,
        CMD_PROFILE,
        CMD_ENVELOPE,
        CMD_FETCH,
        CMD_TERM_RESP,
        CMD_GET_RESP,
        CMD_SEARCH,
        CMD_SELECT,
        CMD_INCREASE,
        CMD_OTHER
    } cmd_kind_t;

    typedef enum logic [1:0] {
        ST_OK,
        ST_WRONG_PARAM,
        ST_WRONG_LEN,
        ST_TECH_PROBLEM
    } status_t;

    typedef struct packed {
        cmd_kind_t   kind;
        logic [7:0]  p1;
        logic [7:0]  p2;
        logic        lc_present;
        logic [7:0]  lc;
        logic        le_present;
        logic [7:0]  le;
    } cmd_hdr_t;

    typedef struct packed {
        status_t     status;
        logic        key_specific;
        logic        key_implicit;
        logic [4:0]  key_number;
        logic [8:0]  data_len;
    } verdict_t;

    localparam logic [7:0] PARAM_FIXED   = 8'h00;
    localparam int         KEY_SCOPE_BIT = 7;
    localparam int         RFU_HI_BIT    = 6;
    localparam int         RFU_LO_BIT    = 5;
    localparam int         KEY_NUM_HI    = 4;
    localparam logic [1:0] RFU_VALUE     = 2'h0;
    localparam logic [4:0] KEY_NUM_MIN   = 5'h01;
    localparam logic [4:0] KEY_NUM_MAX   = 5'h1F;
    localparam logic [7:0] LE_ALL        = 8'h00;
    localparam int         RESP_DEPTH    = 256;

endpackage
`default_nettype wire

// *** resp_store.sv ***
// Byte store that holds response data awaiting retrieval.
`timescale 1ns/10ps
`default_nettype none
module resp_store #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic [7:0]         rd_data
);
    logic [7:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << AW)) $error("resp_store: DEPTH exceeds address range");
    end

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data comes from a register, one cycle after the address.
    always_ff @(posedge clk_sys) begin
        rd_data <= mem[rd_addr];
    end
endmodule // resp_store
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the card command checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import card_cmd_pkg::*;
    logic       clk_sys;
    logic       rst;
    logic       cmd_valid;
    logic       cmd_ready;
    cmd_hdr_t   cmd_hdr;
    logic       verdict_valid;
    verdict_t   verdict;
    logic       resp_load_valid;
    logic       resp_load_ready;
    logic [7:0] resp_load_data;
    logic       out_valid;
    logic [7:0] out_data;
    logic       out_last;
    int         n_fail;
    int         num_checks;

    card_cmd_checker dut_u (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_hdr(cmd_hdr), .verdict_valid(verdict_valid),
        .verdict(verdict), .resp_load_valid(resp_load_valid),
        .resp_load_ready(resp_load_ready), .resp_load_data(resp_load_data),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last));
    term_model term_u (.clk_sys(clk_sys), .cmd_ready(cmd_ready),
        .verdict_valid(verdict_valid), .verdict(verdict), .cmd_valid(cmd_valid),
        .cmd_hdr(cmd_hdr));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish;
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    function automatic cmd_hdr_t mk(cmd_kind_t k, logic [7:0] p1, logic [7:0] p2,
                                    logic lp, logic ep, logic [7:0] le);
        return '{kind: k, p1: p1, p2: p2, lc_present: lp, lc: 8'h08, le_present: ep, le: le};
    endfunction

    task automatic send(input cmd_hdr_t h, input int gap, output verdict_t v);
        bit ok;
        term_u.issue(h, gap, v, ok);
        if (!ok) begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    task automatic expect_st(input cmd_hdr_t h, input status_t st, input int gap);
        verdict_t v;
        send(h, gap, v);
        check(v.status, st, "status");
    endtask

    task automatic auth(input logic [7:0] p1, input logic [7:0] p2, input logic lp,
                        input logic ep, input status_t st, input logic [6:0] key);
        verdict_t v;
        send(mk(CMD_AUTH, p1, p2, lp, ep, 8'h10), 0, v);
        check(v.status, st, "auth status");
        if (st == ST_OK) begin
            check({v.key_specific, v.key_implicit, v.key_number}, key, "key");
        end
    endtask

    task automatic load(input int n, input logic [7:0] base);
        @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            resp_load_valid <= 1'b1;
            resp_load_data  <= base + 8'(i);
            for (int t = 0; t <= 50; t++) begin
                @(posedge clk_sys);
                if (resp_load_ready === 1'b1) break;
                if (t == 50) begin
                    n_fail++;
                    tally_and_finish();
                end
            end
        end
        resp_load_valid <= 1'b0;
        resp_load_data  <= ~resp_load_data;
    endtask

    task automatic stream(input int n, input logic [7:0] base, input logic [7:0] le);
        verdict_t v;
        send(mk(CMD_GET_RESP, 8'h00, 8'h00, 1'b0, 1'b1, le), 0, v);
        check(v.status, ST_OK, "get status");
        check(v.data_len, 9'(n), "get length");
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            #1;
            check({out_valid, out_last, cmd_ready, resp_load_ready, out_data},
                  {1'b1, i == n - 1, i == n - 1, i == n - 1, base + 8'(i)}, "stream byte");
        end
        @(posedge clk_sys);
        #1;
        check(out_valid, 1'b0, "stream end");
    endtask

    task automatic sc_first_get;
        expect_st(mk(CMD_GET_RESP, 8'h00, 8'h00, 1'b0, 1'b1, LE_ALL), ST_OK, 0);
        expect_st(mk(CMD_GET_RESP, 8'h00, 8'h00, 1'b0, 1'b1, LE_ALL), ST_TECH_PROBLEM, 0);
    endtask

    task automatic sc_auth;
        auth(8'h00, 8'h00, 1'b1, 1'b1, ST_OK, 7'h20);
        auth(8'h00, 8'h01, 1'b1, 1'b1, ST_OK, 7'h01);
        auth(8'h00, 8'h9F, 1'b1, 1'b1, ST_OK, 7'h5F);
        auth(8'h01, 8'h01, 1'b1, 1'b1, ST_WRONG_PARAM, 7'h00);
        auth(8'h00, 8'h21, 1'b1, 1'b1, ST_WRONG_PARAM, 7'h00);
        auth(8'h00, 8'h41, 1'b1, 1'b1, ST_WRONG_PARAM, 7'h00);
        auth(8'h00, 8'h80, 1'b1, 1'b1, ST_WRONG_PARAM, 7'h00);
        auth(8'h00, 8'h01, 1'b1, 1'b0, ST_WRONG_LEN, 7'h00);
        auth(8'h00, 8'h01, 1'b0, 1'b1, ST_WRONG_LEN, 7'h00);
    endtask

    task automatic sc_toolkit;
        cmd_kind_t ks[4]  = '{CMD_PROFILE, CMD_ENVELOPE, CMD_FETCH, CMD_TERM_RESP};
        logic      lcs[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        logic      les[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            expect_st(mk(ks[i], 8'h00, 8'h00, lcs[i], les[i], 8'h04),
                      ST_OK, i);
            expect_st(mk(ks[i], 8'h00, 8'h00, !lcs[i], les[i], 8'h04), ST_WRONG_LEN, 0);
            expect_st(mk(ks[i], 8'h00, 8'h00, lcs[i], !les[i], 8'h04), ST_WRONG_LEN, 0);
            expect_st(mk(ks[i], 8'h01, 8'h00, lcs[i], les[i], 8'h04), ST_WRONG_PARAM, 0);
            expect_st(mk(ks[i], 8'h00, 8'h80, lcs[i], les[i], 8'h04), ST_WRONG_PARAM, 0);
        end
    endtask

    task automatic sc_chain;
        cmd_hdr_t gr;
        gr = mk(CMD_GET_RESP, 8'h00, 8'h00, 1'b0, 1'b1, LE_ALL);
        auth(8'h00, 8'h01, 1'b1, 1'b1, ST_OK, 7'h01);
        load(3, 8'hA0);
        stream(3, 8'hA0, LE_ALL);
        expect_st(mk(CMD_SELECT, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00), ST_OK, 0);
        load(2, 8'h5C);
        stream(2, 8'h5C, 8'h02);
        expect_st(mk(CMD_SEARCH, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00), ST_OK, 0);
        load(2, 8'h33);
        expect_st(mk(CMD_GET_RESP, 8'h00, 8'h00, 1'b0, 1'b1, 8'h05), ST_WRONG_LEN, 0);
        expect_st(mk(CMD_INCREASE, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00), ST_OK, 0);
        expect_st(mk(CMD_FETCH, 8'h00, 8'h00, 1'b0, 1'b1, 8'h04), ST_OK, 0);
        expect_st(gr, ST_TECH_PROBLEM, 0);
        auth(8'h01, 8'h01, 1'b1, 1'b1, ST_WRONG_PARAM, 7'h00);
        expect_st(gr, ST_TECH_PROBLEM, 0);
        auth(8'h00, 8'h05, 1'b1, 1'b1, ST_OK, 7'h05);
        expect_st(mk(CMD_OTHER, 8'h12, 8'h34, 1'b0, 1'b0, 8'h00), ST_OK, 0);
        expect_st(gr, ST_TECH_PROBLEM, 0);
    endtask

    // A second activation must re-arm the chain even after it was consumed.
    task automatic sc_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check({verdict_valid, out_valid, cmd_ready, resp_load_ready}, 4'h3, "reset idle");
        expect_st(mk(CMD_GET_RESP, 8'h00, 8'h00, 1'b0, 1'b1, LE_ALL), ST_OK, 0);
    endtask

    initial begin
        n_fail          = 0;
        num_checks      = 0;
        rst             = 1'b1;
        resp_load_valid = 1'b0;
        resp_load_data  = 8'h00;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        sc_first_get();
        sc_auth();
        sc_toolkit();
        sc_chain();
        sc_reset();
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire

// *** term_model.sv ***
// Terminal model that offers command headers to the card command checker.
`timescale 1ns/10ps
`default_nettype none
module term_model
    import card_cmd_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     cmd_ready,
    input  wire logic     verdict_valid,
    input  wire verdict_t verdict,
    output logic          cmd_valid,
    output cmd_hdr_t      cmd_hdr
);
    initial begin
        cmd_valid = 1'b0;
        cmd_hdr   = '0;
    end

    // Callers pick the order of commands, so get-response placement is theirs to get right.
    task automatic issue(input cmd_hdr_t h, input int gap, output verdict_t v, output bit ok);
        ok = 1'b0;
        v  = '0;
        repeat (gap + 1) @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_hdr   <= h;
        for (int i = 0; i < 100 && !ok; i++) begin
            @(posedge clk_sys);
            ok = cmd_ready;
        end
        cmd_valid <= 1'b0;
        // A released header shows its inverse so that a stale value is never read as live.
        cmd_hdr   <= cmd_hdr_t'(~h);
        #1;
        if (verdict_valid !== 1'b1) ok = 1'b0;
        v = verdict;
    endtask
endmodule // term_model
`default_nettype wire
